// File: hw/rte_defs.svh
// Constants for the receive tag, event mask, event status and timeout registers.
// Assumes the includer uses 16-bit register addresses and 8-bit register data.
`ifndef RTE_DEFS_SVH
`define RTE_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register addresses
`define RTE_ADDR_MODE     16'h8006
`define RTE_ADDR_MASK     16'h8007
`define RTE_ADDR_STATUS   16'h8008
`define RTE_ADDR_TIMEOUT  16'h8009

////////////////////////////////////////////////////////////////////////////////
// Field positions and reset values
`define RTE_MODE_PIN_MSB  5
`define RTE_MODE_EE_BIT   6
`define RTE_EVT_MSB       2
`define RTE_MODE_RST      7'h00
`define RTE_EVT_RST       3'h0
`define RTE_RDATA_RST     8'h00

////////////////////////////////////////////////////////////////////////////////
// Timing: 25 ms pending limit at a 50 ns system clock
`define RTE_TIMEOUT_MS     25
`define RTE_CLK_PERIOD_NS  50
`define RTE_TIMEOUT_CYC    ((`RTE_TIMEOUT_MS * 1000000) / `RTE_CLK_PERIOD_NS)
`define RTE_TMR_W          20
`define RTE_STRAP_WAIT     2'h2

`endif

// File: hw/rte_pkg.sv
// Types shared by the register bank and its event timers.
// Assumes rte_defs.svh is compiled alongside.
`include "rte_defs.svh"

package rte_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Receive tag and mode register, bit 0 at the bottom
    typedef struct packed {
        logic       eeprom_init;
        logic       inband_dir;
        logic       clk_dir;
        logic       strip;
        logic [2:0] tag_size;
    } rte_mode_t;

    // One bit per event: bit 0 PHY, bit 1 Rx null, bit 2 Tx null
    typedef struct packed {
        logic tx_null;
        logic rx_null;
        logic phy;
    } rte_evt_t;

    // Start-up phases, one-hot
    typedef enum logic [2:0] {
        RTE_PH_SYNC = 3'b001,
        RTE_PH_LOAD = 3'b010,
        RTE_PH_RUN  = 3'b100
    } rte_phase_t;

    typedef struct packed {
        rte_phase_t  phase;
        logic [1:0]  wait_cnt;
        rte_mode_t   mode;
        rte_evt_t    mask;
        rte_evt_t    status;
        rte_evt_t    notify;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        irq_meta;
        logic        irq_sync;
        logic        irq_prev;
        logic [5:0]  strap_meta;
        logic [5:0]  strap_sync;
        logic        clk_oe;
    } rte_regs_state_t;

    typedef struct packed {
        logic [`RTE_TMR_W-1:0] cnt;
        logic                  timeout;
    } rte_tmr_state_t;

endpackage : rte_pkg

// File: hw/rte_event_timer.sv
// Pending-time watchdog for one event status flag.
// Assumes i_pending is a registered status bit and i_service a one-cycle pulse.
`include "rte_defs.svh"

module rte_event_timer #(
    parameter int unsigned LIMIT = `RTE_TIMEOUT_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_pending,
    input  wire logic i_service,
    output logic      o_timeout
);

    localparam logic [`RTE_TMR_W-1:0] LIM_M1 = `RTE_TMR_W'(LIMIT - 1);

    rte_pkg::rte_tmr_state_t st;
    rte_pkg::rte_tmr_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Count while pending; a service write restarts the measurement
    always_comb begin
        next_st = st;
        if (i_service) begin
            next_st.cnt     = '0;                                // RQ13
            next_st.timeout = 1'b0;                              // RQ13
        end else if (i_pending && !st.timeout) begin
            if (st.cnt == LIM_M1) begin
                next_st.timeout = 1'b1;                          // RQ12
                next_st.cnt     = '0;
            end else begin
                next_st.cnt = st.cnt + 1'b1;                     // RQ15
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_timeout = st.timeout;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    timeout_at_limit_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ12
        $rose(st.timeout) |-> $past(st.cnt) == LIM_M1 && $past(i_pending))
        else $error("timeout set before the pending limit");

    counter_idle_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ15
        !i_pending && !i_service |=> $stable(st.cnt))
        else $error("timer counted without a pending event");

endmodule // rte_event_timer

// File: hw/rte_regs.sv
// Receive tag/mode, event mask, event status and timeout registers.
// Assumes register accesses arrive decoded from in-band programming cells as
// one-cycle read or write strobes on the system clock; strap and PHY interrupt
// pins are asynchronous and are synchronised here.
`include "rte_defs.svh"

// Overview of operation
// (RQ1) Tag size bits drive added tag bytes
// (RQ2) Bit 3 set strips the check byte
// (RQ3) Bit 4 zero drives receive clock out
// (RQ4) Bit 5 picks programming cell interface
// (RQ5) Bit 6 requests EEPROM header copy, default 0
// (RQ6) PHY mask bit enables notification cell
// (RQ7) Rx null mask bit enables notification
// (RQ8) Tx null mask bit enables notification
// (RQ9) PHY interrupt sets status bit 0
// (RQ10) Rx null pointer sets status bit 1
// (RQ11) Tx null pointer sets status bit 2
// (RQ12) Timeout bit after 25 ms unserviced
// (RQ13) Status write clears the timeout bits
// (RQ14) Pin fields writable only with override
// (RQ15) Per-event counter measures pending time
// (RQ16) Unused bits read zero, ignore writes
module rte_regs #(
    parameter int unsigned TIMEOUT_CYC = `RTE_TIMEOUT_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [15:0] i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    input  wire logic        i_pin_override,
    input  wire logic [5:0]  i_mode_straps,
    input  wire logic        i_phy_irq_input,
    input  wire logic        i_rx_null_hit,
    input  wire logic        i_tx_null_hit,
    output logic [7:0]       o_reg_rdata,
    output logic             o_reg_rvalid,
    output logic             o_ready,
    output logic [2:0]       o_rx_tag_size,
    output logic             o_rx_strip_check_byte,
    output logic             o_nibble_port_clock_dir,
    output logic             o_rx_nibble_port_clock_oe,
    output logic             o_inband_dir,
    output logic             o_eeprom_init_en,
    output logic [2:0]       o_notify_evt
);

    rte_pkg::rte_regs_state_t st;
    rte_pkg::rte_regs_state_t next_st;
    rte_pkg::rte_evt_t        evt;
    rte_pkg::rte_evt_t        timeout;
    logic                     svc;
    logic                     wr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped addresses and unused bits read zero
    function automatic logic [7:0] rd_mux(input logic [15:0] addr,
                                          input rte_pkg::rte_mode_t mode,
                                          input rte_pkg::rte_evt_t mask,
                                          input rte_pkg::rte_evt_t status,
                                          input rte_pkg::rte_evt_t tmo);
        logic [7:0] v;
        v = `RTE_RDATA_RST;
        if (addr == `RTE_ADDR_MODE) begin
            v = {1'b0, mode};
        end else if (addr == `RTE_ADDR_MASK) begin
            v = {5'h00, mask};
        end else if (addr == `RTE_ADDR_STATUS) begin
            v = {5'h00, status};
        end else if (addr == `RTE_ADDR_TIMEOUT) begin
            v = {5'h00, tmo};
        end
        return v;
    endfunction

    // Write hits one register only when the bank is running
    function automatic logic wr_hit(input logic wr, input logic run,
                                    input logic [15:0] addr, input logic [15:0] reg_addr);
        return wr && run && (addr == reg_addr);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event sources: PHY interrupt edge on the synchronised pin
    assign evt.phy     = st.irq_sync && !st.irq_prev;
    assign evt.rx_null = i_rx_null_hit;
    assign evt.tx_null = i_tx_null_hit;
    assign wr_ok       = st.phase == rte_pkg::RTE_PH_RUN;
    assign svc         = wr_hit(i_reg_wr, wr_ok, i_reg_addr, `RTE_ADDR_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // One watchdog per event flag
    genvar gi;
    generate
        for (gi = 0; gi <= `RTE_EVT_MSB; gi++) begin : g_tmr
            rte_event_timer #(
                .LIMIT     (TIMEOUT_CYC)
            ) u_tmr (
                .i_clk     (i_clk),
                .i_nrst    (i_nrst),
                .i_pending (st.status[gi]),                      // RQ15
                .i_service (svc),                                // RQ13
                .o_timeout (timeout[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st            = st;
        next_st.irq_meta   = i_phy_irq_input;
        next_st.irq_sync   = st.irq_meta;
        next_st.irq_prev   = st.irq_sync;
        next_st.strap_meta = i_mode_straps;
        next_st.strap_sync = st.strap_meta;
        next_st.rvalid     = 1'b0;
        next_st.notify     = `RTE_EVT_RST;

        // Straps are caught only once the synchroniser has filled
        case (st.phase)
            rte_pkg::RTE_PH_SYNC: begin
                next_st.wait_cnt = st.wait_cnt + 1'b1;
                if (st.wait_cnt == `RTE_STRAP_WAIT) begin
                    next_st.phase = rte_pkg::RTE_PH_LOAD;
                end
            end
            rte_pkg::RTE_PH_LOAD: begin
                next_st.mode[`RTE_MODE_PIN_MSB:0] = st.strap_sync;
                next_st.phase = rte_pkg::RTE_PH_RUN;
            end
            rte_pkg::RTE_PH_RUN: begin
                next_st.phase = rte_pkg::RTE_PH_RUN;
            end
            default: begin
                next_st.phase = rte_pkg::RTE_PH_SYNC;
            end
        endcase

        // Mode register: pin fields locked unless overridden
        if (wr_hit(i_reg_wr, wr_ok, i_reg_addr, `RTE_ADDR_MODE)) begin
            if (i_pin_override) begin
                next_st.mode[`RTE_MODE_PIN_MSB:0] = i_reg_wdata[`RTE_MODE_PIN_MSB:0]; // RQ14
            end
            next_st.mode.eeprom_init = i_reg_wdata[`RTE_MODE_EE_BIT];                // RQ5
        end

        if (wr_hit(i_reg_wr, wr_ok, i_reg_addr, `RTE_ADDR_MASK)) begin
            next_st.mask = rte_pkg::rte_evt_t'(i_reg_wdata[`RTE_EVT_MSB:0]);         // RQ16
        end

        // Status: write one to clear, a same-cycle event wins
        if (svc) begin
            next_st.status = st.status & ~rte_pkg::rte_evt_t'(i_reg_wdata[`RTE_EVT_MSB:0]);
        end
        next_st.status = next_st.status | evt;                   // RQ9 RQ10 RQ11

        // Notification request only for unmasked events
        next_st.notify = evt & st.mask;                          // RQ6 RQ7 RQ8

        // Clock direction: switch mode drives the receive clock, but only once
        // the straps are in, so the pin never fights a board that drives it
        next_st.clk_oe = (next_st.phase == rte_pkg::RTE_PH_RUN) && !next_st.mode.clk_dir; // RQ3

        if (i_reg_rd) begin
            next_st.rdata  = rd_mux(i_reg_addr, st.mode, st.mask, st.status, timeout); // RQ16
            next_st.rvalid = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st       <= '0;
            st.phase <= rte_pkg::RTE_PH_SYNC;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from state
    assign o_reg_rdata               = st.rdata;
    assign o_reg_rvalid              = st.rvalid;
    assign o_ready                   = st.phase == rte_pkg::RTE_PH_RUN;
    assign o_rx_tag_size             = st.mode.tag_size;         // RQ1
    assign o_rx_strip_check_byte     = st.mode.strip;            // RQ2
    assign o_nibble_port_clock_dir   = st.mode.clk_dir;          // RQ3
    assign o_rx_nibble_port_clock_oe = st.clk_oe;
    assign o_inband_dir              = st.mode.inband_dir;       // RQ4
    assign o_eeprom_init_en          = st.mode.eeprom_init;      // RQ5
    assign o_notify_evt              = st.notify;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    tag_size_write_a: assert property ( // RQ1
        wr_ok && i_reg_wr && i_reg_addr == `RTE_ADDR_MODE && i_pin_override
        |=> o_rx_tag_size == $past(i_reg_wdata[2:0]))
        else $error("tag size did not follow an override write");

    strip_write_a: assert property ( // RQ2
        wr_ok && i_reg_wr && i_reg_addr == `RTE_ADDR_MODE && i_pin_override
        |=> o_rx_strip_check_byte == $past(i_reg_wdata[3]))
        else $error("strip bit did not follow write");

    clock_dir_a: assert property ( // RQ3
        o_rx_nibble_port_clock_oe == (o_ready && !o_nibble_port_clock_dir))
        else $error("receive clock enable disagrees with direction");

    inband_dir_a: assert property ( // RQ4
        wr_ok && i_reg_wr && i_reg_addr == `RTE_ADDR_MODE && i_pin_override
        |=> o_inband_dir == $past(i_reg_wdata[5]))
        else $error("in-band direction did not follow write");

    eeprom_reset_a: assert property ( // RQ5
        !wr_ok |-> !o_eeprom_init_en)
        else $error("EEPROM copy requested without a write");

    phy_notify_a: assert property ( // RQ6
        evt.phy |=> o_notify_evt[0] == $past(st.mask.phy))
        else $error("PHY notification disagrees with mask");

    rx_notify_a: assert property ( // RQ7
        !evt.rx_null |=> !o_notify_evt[1])
        else $error("Rx null notification without event");

    tx_notify_a: assert property ( // RQ8
        evt.tx_null && st.mask.tx_null |=> o_notify_evt[2])
        else $error("Tx null notification missing");

    phy_status_a: assert property ( // RQ9
        evt.phy |=> st.status.phy)
        else $error("PHY status not set");

    rx_status_a: assert property ( // RQ10
        evt.rx_null |=> st.status.rx_null)
        else $error("Rx null status not set");

    tx_status_a: assert property ( // RQ11
        evt.tx_null |=> st.status.tx_null)
        else $error("Tx null status not set");

    timeout_clear_a: assert property ( // RQ13
        svc |=> timeout == 3'h0)
        else $error("timeout bits survived a status write");

    locked_pins_a: assert property ( // RQ14
        wr_ok && !i_pin_override |=> $stable(st.mode[5:0]))
        else $error("pin field changed while locked");

    unmapped_read_a: assert property ( // RQ16
        i_reg_rd && i_reg_addr == 16'h8005 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read returned data");

    reset_timeout_a: assert property ( // RQ12
        st.status == 3'h0 |-> ##1 timeout == 3'h0 || $past(timeout) != 3'h0)
        else $error("timeout rose with nothing pending");

    status_write_cv: cover property (svc && st.status != 3'h0);
    notify_cv: cover property (o_notify_evt != 3'h0);
    timeout_cv: cover property (timeout != 3'h0);
    override_cv: cover property (wr_ok && i_reg_wr && i_pin_override);

endmodule // rte_regs

// File: testbench/tb_top.sv
// Self-checking bench for the receive tag, event mask, status and timeout registers.
// Assumes rte_regs with a shortened pending limit; all inputs change at falling edges.
`include "rte_defs.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned TMO  = 20;
    localparam int          CEIL = 6000;

    logic        i_clk;
    logic        i_nrst;
    logic        i_reg_wr;
    logic        i_reg_rd;
    logic [15:0] i_reg_addr;
    logic [7:0]  i_reg_wdata;
    logic        i_pin_override;
    logic [5:0]  i_mode_straps;
    logic        i_phy_irq_input;
    logic        i_rx_null_hit;
    logic        i_tx_null_hit;
    logic [7:0]  o_reg_rdata;
    logic        o_reg_rvalid;
    logic        o_ready;
    logic [2:0]  o_rx_tag_size;
    logic        o_rx_strip_check_byte;
    logic        o_nibble_port_clock_dir;
    logic        o_rx_nibble_port_clock_oe;
    logic        o_inband_dir;
    logic        o_eeprom_init_en;
    logic [2:0]  o_notify_evt;

    int          bad_count;
    int          n_compared;
    int          cyc;
    logic [7:0]  exp_q[$];
    string       name_q[$];
    logic [7:0]  st;
    logic [6:0]  mv;

    rte_regs #(.TIMEOUT_CYC(TMO)) dut_u (
        .i_clk                     (i_clk),
        .i_nrst                    (i_nrst),
        .i_reg_wr                  (i_reg_wr),
        .i_reg_rd                  (i_reg_rd),
        .i_reg_addr                (i_reg_addr),
        .i_reg_wdata               (i_reg_wdata),
        .i_pin_override            (i_pin_override),
        .i_mode_straps             (i_mode_straps),
        .i_phy_irq_input           (i_phy_irq_input),
        .i_rx_null_hit             (i_rx_null_hit),
        .i_tx_null_hit             (i_tx_null_hit),
        .o_reg_rdata               (o_reg_rdata),
        .o_reg_rvalid              (o_reg_rvalid),
        .o_ready                   (o_ready),
        .o_rx_tag_size             (o_rx_tag_size),
        .o_rx_strip_check_byte     (o_rx_strip_check_byte),
        .o_nibble_port_clock_dir   (o_nibble_port_clock_dir),
        .o_rx_nibble_port_clock_oe (o_rx_nibble_port_clock_oe),
        .o_inband_dir              (o_inband_dir),
        .o_eeprom_init_en          (o_eeprom_init_en),
        .o_notify_evt              (o_notify_evt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock, 50 ns period
    initial i_clk = 1'b0;
    always #25 i_clk = ~i_clk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles: one strobe cycle, then one idle cycle before the next
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
        @(negedge i_clk);
        exp_q.push_back(e);
        name_q.push_back(nm);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(negedge i_clk);
        i_reg_rd <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(negedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    // Raise one event and collect any notification pulses over six cycles
    task automatic evt(input int b, input logic [2:0] m);
        logic [2:0] seen;
        seen = 3'h0;
        @(negedge i_clk);
        i_phy_irq_input <= (b == 0);
        i_rx_null_hit   <= (b == 1);
        i_tx_null_hit   <= (b == 2);
        for (int k = 0; k < 6; k++) begin
            @(negedge i_clk);
            i_rx_null_hit <= 1'b0;
            i_tx_null_hit <= 1'b0;
            if (k == 2) i_phy_irq_input <= 1'b0;  // Low long enough for the next rise
            seen |= o_notify_evt;
        end
        check("notify", {5'h0, seen}, {5'h0, m & (3'h1 << b)});
    endtask

    task automatic chk_mode(input logic [6:0] m);
        logic [7:0] outs;
        outs = {1'b0, o_eeprom_init_en, o_inband_dir, o_nibble_port_clock_dir,
                o_rx_strip_check_byte, o_rx_tag_size};
        check("mode_out", outs, {1'b0, m});
        check("clk_oe", {7'h0, o_rx_nibble_port_clock_oe}, {7'h0, ~m[4]});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Read monitor: oldest note against each read answer
    always @(negedge i_clk) begin
        if (o_reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("BAD rvalid expected none seen %h", o_reg_rdata);
            end else begin
                check(name_q.pop_front(), o_reg_rdata, exp_q.pop_front());
            end
        end
    end

    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == CEIL) begin
            bad_count++;
            $display("BAD cycles expected below %0d seen %0d", CEIL, cyc);
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        i_nrst          = 1'b0;
        i_reg_wr        = 1'b0;
        i_reg_rd        = 1'b0;
        i_reg_addr      = 16'h0000;
        i_reg_wdata     = 8'h00;
        i_pin_override  = 1'b0;
        i_phy_irq_input = 1'b0;
        i_rx_null_hit   = 1'b0;
        i_tx_null_hit   = 1'b0;
        st              = lfsr(8'h5e);
        i_mode_straps   = st[5:0];
        repeat (10) @(negedge i_clk);
        i_nrst <= 1'b1;
        wr(`RTE_ADDR_MASK, 8'hff);  // Too early: ready is still low
        check("clk_oe_sync", {7'h0, o_rx_nibble_port_clock_oe}, 8'h00);
        for (int k = 0; k < 20 && o_ready !== 1'b1; k++) @(negedge i_clk);
        check("ready", {7'h0, o_ready}, 8'h01);
        // Reset values and strap capture
        mv = {1'b0, i_mode_straps};
        rd(`RTE_ADDR_MASK, 8'h00, "mask");
        rd(`RTE_ADDR_STATUS, 8'h00, "status");
        rd(`RTE_ADDR_TIMEOUT, 8'h00, "timeout");
        rd(`RTE_ADDR_MODE, {1'b0, mv}, "mode");
        chk_mode(mv);
        // Pin fields locked unless override; bit 7 never sticks
        for (int k = 0; k < 6; k++) begin
            st = lfsr(st);
            i_pin_override <= k[0];
            wr(`RTE_ADDR_MODE, st);
            mv = k[0] ? st[6:0] : {st[6], mv[5:0]};
            rd(`RTE_ADDR_MODE, {1'b0, mv}, "mode");
            chk_mode(mv);
        end
        wr(`RTE_ADDR_MASK, 8'hff);
        rd(`RTE_ADDR_MASK, 8'h07, "mask");
        // Every mask value against every event
        for (int m = 0; m < 8; m++) begin
            wr(`RTE_ADDR_MASK, m[7:0]);
            for (int b = 0; b < 3; b++) evt(b, m[2:0]);
        end
        rd(`RTE_ADDR_STATUS, 8'h07, "status");
        rd(`RTE_ADDR_TIMEOUT, 8'h07, "timeout");
        // Any status write services; only ones clear the flags
        wr(`RTE_ADDR_STATUS, 8'h00);
        rd(`RTE_ADDR_TIMEOUT, 8'h00, "timeout");
        rd(`RTE_ADDR_STATUS, 8'h07, "status");
        wr(`RTE_ADDR_STATUS, 8'h07);
        rd(`RTE_ADDR_STATUS, 8'h00, "status");
        repeat (30) @(negedge i_clk);
        rd(`RTE_ADDR_TIMEOUT, 8'h00, "timeout");
        // Pending-time limit on one event: one read well before it, one well after
        evt(1, 3'h7);
        rd(`RTE_ADDR_TIMEOUT, 8'h00, "timeout");
        repeat (25) @(negedge i_clk);
        rd(`RTE_ADDR_TIMEOUT, 8'h02, "timeout");
        wr(`RTE_ADDR_TIMEOUT, 8'hff);
        rd(`RTE_ADDR_TIMEOUT, 8'h02, "timeout");
        rd(16'h8005, 8'h00, "unmapped");
        wr(`RTE_ADDR_STATUS, 8'h02);
        rd(`RTE_ADDR_STATUS, 8'h00, "status");
        rd(`RTE_ADDR_TIMEOUT, 8'h00, "timeout");
        repeat (3) @(negedge i_clk);
        check("pending_reads", exp_q.size() == 0 ? 8'h00 : 8'hff, 8'h00);
        wrap_up();
    end

endmodule // tb_top
